// *** qrrs_pkg.sv ***
// Constants shared by the quad rail reset supervisor.
// Overview of operation
// [R1] A channel whose release conditions hold keeps its reset asserted for its delay, then releases.
// [R2] A channel whose release conditions fail asserts its reset at once.
// [R3] Channel one is asserted while manual reset is low or rail one is under threshold.
// [R4] Channel two is asserted while rail two is under threshold and released after delay above it.
// [R5] Channel three is asserted while rail three is under threshold and released after delay above it.
// [R6] Channel four releases only with the low sense above and the high sense below threshold.
// [R7] Channels one to three assert as soon as their rail drops under the falling threshold.
// [R8] Channel four asserts whenever its high sense reports over-voltage.
// [R9] Watchdog timeout occurs only with channel one released and no kick edge for the period.
// [R10] Both kick edges restart the count; the host must toggle within the period.
// [R11] A latched timeout holds regardless of further kick activity.
// [R12] The countdown starts when channel one releases and restarts in full on each kick edge.
// [R13] A latched timeout clears only when channel one's reset becomes asserted.
// [R14] Each channel picks its delay alone: long when its select pin is high, short when open.
// [R15] All inputs are synchronised before use and durations are counted in clock cycles; the delay select pins are used unsynchronised.
// [R16] After power-on reset all resets are asserted and the watchdog flag is inactive.
package qrrs_pkg;
	localparam int unsigned QRRS_CLK_HZ = 40000000;
	localparam int unsigned QRRS_LONG_DELAY_MS = 315;
	localparam int unsigned QRRS_SHORT_DELAY_MS = 21;
	localparam int unsigned QRRS_WDT_MS = 630;
	localparam int unsigned QRRS_CYC_PER_MS = QRRS_CLK_HZ / 1000;
	localparam int unsigned QRRS_LONG_CYC = QRRS_LONG_DELAY_MS * QRRS_CYC_PER_MS;
	localparam int unsigned QRRS_SHORT_CYC = QRRS_SHORT_DELAY_MS * QRRS_CYC_PER_MS;
	localparam int unsigned QRRS_WDT_CYC = QRRS_WDT_MS * QRRS_CYC_PER_MS;
	localparam int unsigned QRRS_CNT_W = 32;
	localparam int unsigned QRRS_NCHAN = 4;
	localparam logic [1:0] QRRS_SYNC_RST = 2'h0;

	// Counters here stop well short of their top value, so the increment is left to wrap.
	function automatic logic [QRRS_CNT_W-1:0] qrrs_count_up(
		input logic [QRRS_CNT_W-1:0] value
	);
		return value + QRRS_CNT_W'(1);
	endfunction
endpackage

// *** qrrs_chan.sv ***
// One supervisor channel: release delay counter and reset output.
`timescale 1ns/1ps
module qrrs_chan
	import qrrs_pkg::*;
#(
	parameter int unsigned LONG_CYC = QRRS_LONG_CYC,
	parameter int unsigned SHORT_CYC = QRRS_SHORT_CYC
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic release_ok,
	input wire logic delay_select_pin,
	output logic chan_reset_out_n
);
	logic [QRRS_CNT_W-1:0] delay_cnt;
	logic [QRRS_CNT_W-1:0] target;

	// The select pin is sampled live; a change mid-delay takes effect at once.
	assign target = delay_select_pin ? QRRS_CNT_W'(LONG_CYC) : QRRS_CNT_W'(SHORT_CYC); // see [R14]

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			delay_cnt <= '0;
			chan_reset_out_n <= 1'b0; // see [R16]
		end else if (!release_ok) begin
			delay_cnt <= '0;
			chan_reset_out_n <= 1'b0; // see [R2]
		end else if (!chan_reset_out_n) begin
			if (qrrs_count_up(delay_cnt) >= target) begin
				chan_reset_out_n <= 1'b1; // see [R1]
			end else begin
				delay_cnt <= qrrs_count_up(delay_cnt);
			end
		end
	end
endmodule

// *** qrrs_top.sv ***
// Quad rail reset supervisor: input synchronisers, four channels and watchdog.
`timescale 1ns/1ps
module qrrs_top
	import qrrs_pkg::*;
#(
	parameter int unsigned LONG_CYC = QRRS_LONG_CYC,
	parameter int unsigned SHORT_CYC = QRRS_SHORT_CYC,
	parameter int unsigned WDT_CYC = QRRS_WDT_CYC
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic rail_sense_one,
	input wire logic rail_sense_two,
	input wire logic rail_sense_three,
	input wire logic rail_sense_four_low,
	input wire logic rail_sense_four_high,
	input wire logic manual_reset_in_n,
	input wire logic watchdog_kick,
	input wire logic [QRRS_NCHAN-1:0] delay_select_pin,
	output logic chan1_reset_out_n,
	output logic chan2_reset_out_n,
	output logic chan3_reset_out_n,
	output logic chan4_reset_out_n,
	output logic watchdog_fault_n,
	output logic watchdog_fault
);
	// Watchdog states: channel one held in reset, counting towards a timeout, or latched fault.
	typedef enum logic [1:0] {
		WDT_HOLD,
		WDT_RUN,
		WDT_FAULT
	} qrrs_wdt_t;

	// Each sense, manual reset and kick input passes two flops and only the second is read, so a metastable first stage
	// never reaches the decision logic.
	logic rail_one_meta;
	logic rail_one_sync;
	logic rail_two_meta;
	logic rail_two_sync;
	logic rail_three_meta;
	logic rail_three_sync;
	logic rail_four_low_meta;
	logic rail_four_low_sync;
	logic rail_four_high_meta;
	logic rail_four_high_sync;
	logic manual_n_meta;
	logic manual_n_sync;
	logic kick_meta;
	logic kick_sync;
	logic kick_prev;
	logic kick_edge;
	logic [QRRS_NCHAN-1:0] release_ok;
	logic [QRRS_NCHAN-1:0] chan_n;
	logic [QRRS_CNT_W-1:0] wdt_limit;
	logic [QRRS_CNT_W-1:0] wdt_cnt;
	logic wdt_expired;
	qrrs_wdt_t wdt_state;
	qrrs_wdt_t next_wdt_state;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			{rail_one_meta, rail_one_sync} <= QRRS_SYNC_RST;
		end else begin
			rail_one_meta <= rail_sense_one; // see [R15]
			rail_one_sync <= rail_one_meta;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			{rail_two_meta, rail_two_sync} <= QRRS_SYNC_RST;
		end else begin
			rail_two_meta <= rail_sense_two; // see [R15]
			rail_two_sync <= rail_two_meta;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			{rail_three_meta, rail_three_sync} <= QRRS_SYNC_RST;
		end else begin
			rail_three_meta <= rail_sense_three; // see [R15]
			rail_three_sync <= rail_three_meta;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			{rail_four_low_meta, rail_four_low_sync} <= QRRS_SYNC_RST;
		end else begin
			rail_four_low_meta <= rail_sense_four_low; // see [R15]
			rail_four_low_sync <= rail_four_low_meta;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			{rail_four_high_meta, rail_four_high_sync} <= QRRS_SYNC_RST;
		end else begin
			rail_four_high_meta <= rail_sense_four_high; // see [R15]
			rail_four_high_sync <= rail_four_high_meta;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			{manual_n_meta, manual_n_sync} <= QRRS_SYNC_RST;
		end else begin
			manual_n_meta <= manual_reset_in_n; // see [R15]
			manual_n_sync <= manual_n_meta;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			{kick_meta, kick_sync} <= QRRS_SYNC_RST;
		end else begin
			kick_meta <= watchdog_kick; // see [R15]
			kick_sync <= kick_meta;
		end
	end

	// A false edge right after reset is harmless: channel one is still asserted then.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			kick_prev <= 1'b0;
		end else begin
			kick_prev <= kick_sync;
		end
	end

	// Either level change of the synchronised kick line counts as service.
	assign kick_edge = kick_sync ^ kick_prev; // see [R10]

	// Rails report high when above threshold; the high sense of channel four reports high on
	// over-voltage, so it enters inverted.
	assign release_ok[0] = manual_n_sync & rail_one_sync; // see [R3] [R7]
	assign release_ok[1] = rail_two_sync; // see [R4] [R7]
	assign release_ok[2] = rail_three_sync; // see [R5] [R7]
	assign release_ok[3] = rail_four_low_sync & ~rail_four_high_sync; // see [R6] [R8]

	genvar gi;
	generate
		for (gi = 0; gi < QRRS_NCHAN; gi++) begin : g_chan
			qrrs_chan #(
				.LONG_CYC(LONG_CYC),
				.SHORT_CYC(SHORT_CYC)
			) u_chan (
				.sys_clk(sys_clk),
				.sys_rst(sys_rst),
				.release_ok(release_ok[gi]),
				.delay_select_pin(delay_select_pin[gi]),
				.chan_reset_out_n(chan_n[gi])
			);
		end
	endgenerate

	assign chan1_reset_out_n = chan_n[0];
	assign chan2_reset_out_n = chan_n[1];
	assign chan3_reset_out_n = chan_n[2];
	assign chan4_reset_out_n = chan_n[3];

	// The limit is cast once so that every compare below works at counter width.
	assign wdt_limit = QRRS_CNT_W'(WDT_CYC);
	assign wdt_expired = !kick_edge && qrrs_count_up(wdt_cnt) >= wdt_limit; // see [R9]

	// The counter saturates at the limit so that a silent kick line cannot wrap it to zero.
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !chan_n[0] || kick_edge) begin
			wdt_cnt <= '0; // see [R12]
		end else if (wdt_state != WDT_FAULT && wdt_cnt < wdt_limit) begin
			wdt_cnt <= qrrs_count_up(wdt_cnt);
		end
	end

	always_comb begin
		next_wdt_state = wdt_state;
		unique case (wdt_state)
			WDT_HOLD: begin
				if (chan_n[0]) begin
					next_wdt_state = WDT_RUN; // see [R12]
				end
			end
			WDT_RUN: begin
				if (!chan_n[0]) begin
					next_wdt_state = WDT_HOLD;
				end else if (wdt_expired) begin
					next_wdt_state = WDT_FAULT; // see [R9]
				end
			end
			WDT_FAULT: begin // see [R11]
				if (!chan_n[0]) begin
					next_wdt_state = WDT_HOLD; // see [R13]
				end
			end
			default: begin
				// The unused code falls back to the safe state with the fault flags clear.
				next_wdt_state = WDT_HOLD;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wdt_state <= WDT_HOLD;
		end else begin
			wdt_state <= next_wdt_state;
		end
	end

	// Both polarities come from their own flops, so neither output carries a gate delay.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			watchdog_fault <= 1'b0; // see [R16]
			watchdog_fault_n <= 1'b1;
		end else begin
			watchdog_fault <= (next_wdt_state == WDT_FAULT); // see [R9]
			watchdog_fault_n <= (next_wdt_state != WDT_FAULT);
		end
	end
endmodule

// *** qrrs_top_sva.sv ***
// Port assertions for the quad rail reset supervisor.
`timescale 1ns/1ps
module qrrs_top_sva(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic rail_sense_one,
	input wire logic rail_sense_two,
	input wire logic rail_sense_three,
	input wire logic rail_sense_four_low,
	input wire logic rail_sense_four_high,
	input wire logic manual_reset_in_n,
	input wire logic watchdog_kick,
	input wire logic chan1_reset_out_n,
	input wire logic chan2_reset_out_n,
	input wire logic chan3_reset_out_n,
	input wire logic chan4_reset_out_n,
	input wire logic watchdog_fault_n,
	input wire logic watchdog_fault,
	input wire logic [3:0] delay_select_pin
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	ch1_assert_a: assert property (
		!manual_reset_in_n || !rail_sense_one |-> ##3 !chan1_reset_out_n)
		else $error("chan1 not asserted");
	ch2_assert_a: assert property (
		!rail_sense_two |-> ##3 !chan2_reset_out_n)
		else $error("chan2 not asserted");
	ch3_assert_a: assert property (
		!rail_sense_three |-> ##3 !chan3_reset_out_n)
		else $error("chan3 not asserted");
	ch4_window_a: assert property (
		!rail_sense_four_low || rail_sense_four_high |-> ##3 !chan4_reset_out_n)
		else $error("chan4 not asserted");
	rel_delay_a: assert property (
		$rose(chan2_reset_out_n) |-> $past(rail_sense_two, 7))
		else $error("chan2 released early");
	fault_pair_a: assert property (
		watchdog_fault_n == !watchdog_fault)
		else $error("fault flags disagree");
	fault_hold_a: assert property (
		watchdog_fault && chan1_reset_out_n |=> watchdog_fault)
		else $error("fault dropped");
	fault_clear_a: assert property (
		$fell(watchdog_fault) |-> $past(!chan1_reset_out_n))
		else $error("fault cleared without reset");
	fault_entry_a: assert property (
		$rose(watchdog_fault) |->
		$past(chan1_reset_out_n) && $past(watchdog_kick, 3) == $past(watchdog_kick, 8))
		else $error("fault set too soon");
	rst_state_a: assert property (disable iff (1'b0)
		sys_rst |=> !chan1_reset_out_n && !chan2_reset_out_n && !chan3_reset_out_n &&
		!chan4_reset_out_n && !watchdog_fault && watchdog_fault_n)
		else $error("bad state after reset");
endmodule
bind qrrs_top qrrs_top_sva u_qrrs_top_sva(
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.rail_sense_one(rail_sense_one),
	.rail_sense_two(rail_sense_two),
	.rail_sense_three(rail_sense_three),
	.rail_sense_four_low(rail_sense_four_low),
	.rail_sense_four_high(rail_sense_four_high),
	.manual_reset_in_n(manual_reset_in_n),
	.watchdog_kick(watchdog_kick),
	.chan1_reset_out_n(chan1_reset_out_n),
	.chan2_reset_out_n(chan2_reset_out_n),
	.chan3_reset_out_n(chan3_reset_out_n),
	.chan4_reset_out_n(chan4_reset_out_n),
	.watchdog_fault_n(watchdog_fault_n),
	.watchdog_fault(watchdog_fault),
	.delay_select_pin(delay_select_pin)
);

// *** qrrs_host.sv ***
// Host model that services the watchdog while its reset is released.
`timescale 1ns/1ps
module qrrs_host(
	input wire logic sys_clk,
	input wire logic chan1_reset_out_n,
	input wire logic kick_en,
	output logic watchdog_kick
);
	int n = 0;
	initial watchdog_kick = 1'b0;
	// Ten cycles between edges keeps well inside the timeout.
	always @(posedge sys_clk) begin
		n <= n + 1;
		if (kick_en && chan1_reset_out_n && n % 10 == 9) begin
			watchdog_kick <= #1 ~watchdog_kick;
		end
	end
endmodule

// *** qrrs_top_bench.sv ***
// Directed bench for the quad rail reset supervisor.
`timescale 1ns/1ps
module qrrs_top_bench;
	localparam int LC = 20;
	localparam int SC = 5;
	localparam int WC = 40;
	logic sys_clk = 0, sys_rst = 1, kick_en = 1, watchdog_kick, wf, wfn;
	logic [5:0] g = 6'h3F;
	logic [3:0] sel = 4'h5;
	logic [3:0] o;
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	qrrs_top #(.LONG_CYC(LC), .SHORT_CYC(SC), .WDT_CYC(WC)) u_qrrs_top(.sys_clk(sys_clk),
		.sys_rst(sys_rst), .rail_sense_one(g[1]), .rail_sense_two(g[2]), .rail_sense_three(g[3]),
		.rail_sense_four_low(g[4]), .rail_sense_four_high(!g[5]), .manual_reset_in_n(g[0]),
		.watchdog_kick(watchdog_kick), .delay_select_pin(sel), .chan1_reset_out_n(o[0]),
		.chan2_reset_out_n(o[1]), .chan3_reset_out_n(o[2]), .chan4_reset_out_n(o[3]),
		.watchdog_fault_n(wfn), .watchdog_fault(wf));
	qrrs_host u_qrrs_host(.sys_clk(sys_clk), .chan1_reset_out_n(o[0]), .kick_en(kick_en),
		.watchdog_kick(watchdog_kick));
	initial forever #12.5 sys_clk = ~sys_clk;
	task automatic step(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(string s, logic [3:0] e, logic [3:0] v);
		checks_done++;
		if (v !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic give_verdict();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic t_release();
		step(SC + 1);
		chk("outs", 4'h0, o);
		step(1);
		chk("outs", 4'hA, o);
		step(LC - SC - 1);
		chk("outs", 4'hA, o);
		step(1);
		chk("outs", 4'hF, o);
		$display("release test done");
	endtask
	task automatic t_drop();
		for (int i = 0; i < 6; i++) begin
			g[i] = 1'b0;
			step(2);
			chk("outs", 4'hF, o);
			step(1);
			chk("outs", ~(4'h1 << (i < 2 ? 0 : i < 4 ? i - 1 : 3)), o);
			g[i] = 1'b1;
			step(LC + 3);
		end
		$display("drop test done");
	endtask
	task automatic t_wdog();
		step(3 * WC);
		chk("fault", 4'h2, {2'h0, wfn, wf});
		kick_en = 0;
		step(WC - 12);
		chk("fault", 4'h2, {2'h0, wfn, wf});
		step(18);
		chk("fault", 4'h1, {2'h0, wfn, wf});
		kick_en = 1;
		step(30);
		chk("fault", 4'h1, {2'h0, wfn, wf});
		g[0] = 0;
		step(4);
		chk("fault", 4'h2, {2'h0, wfn, wf});
		g[0] = 1;
		$display("watchdog test done");
	endtask
	// The ceiling sits well above the few hundred cycles the tests need.
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		step(10);
		chk("outs", 4'h0, o);
		sys_rst = 0;
		t_release();
		t_drop();
		t_wdog();
		give_verdict();
	end
endmodule
